// ### hw/ocp_pkg.sv
// package of constants and types for the overload protection control block
package ocp_pkg;

	// ****************************************
	// register byte addresses (word aligned)
	// ****************************************
	localparam logic [4:0] OCP_ADDR_INPUT_SOURCE = 5'h00;
	localparam logic [4:0] OCP_ADDR_DAC_CODE = 5'h04;
	localparam logic [4:0] OCP_ADDR_SWITCH = 5'h08;
	localparam logic [4:0] OCP_ADDR_PROTECT = 5'h0C;
	localparam logic [4:0] OCP_ADDR_GAIN_DEB = 5'h10;
	localparam logic [4:0] OCP_ADDR_AMP_CAL = 5'h14;
	localparam logic [4:0] OCP_ADDR_CMP_CAL = 5'h18;
	localparam logic [4:0] OCP_ADDR_IRQ_STATUS = 5'h1C;

	// ****************************************
	// extra interrupt registers
	// ****************************************
	localparam logic [5:0] OCP_ADDR_IRQ_CLEAR = 6'h20;
	localparam logic [5:0] OCP_ADDR_IRQ_ENABLE = 6'h24;

	// ****************************************
	// field positions
	// ****************************************
	localparam int OCP_BIT_ENABLE = 7;
	localparam int OCP_BIT_HYST = 6;
	localparam int OCP_BIT_DEBOUNCED = 5;
	localparam int OCP_BIT_POLARITY = 4;
	localparam int OCP_BIT_CMP_SRC = 1;
	localparam int OCP_BIT_DAC_REF = 0;
	localparam int OCP_BIT_DOUBLE = 6;
	localparam int OCP_GAIN_LSB = 3;
	localparam int OCP_DEB_LSB = 0;
	localparam int OCP_BIT_CMP_RAW = 7;
	localparam int OCP_BIT_IRQ_PROTECT = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] OCP_RST_SWITCH = 8'hC8;
	localparam logic [7:0] OCP_RST_ZERO = 8'h00;
	localparam logic [7:0] OCP_RST_AMP_CAL = 8'h20;
	localparam logic [6:0] OCP_RST_CMP_CAL = 7'h10;

	// ****************************************
	// timing
	// ****************************************
	localparam int OCP_DEB_CNT_W = 7;

	// control outputs travelling to the analog front end
	typedef struct packed {
		logic [1:0] input_pin_select;
		logic [7:0] switch_controls;
		logic [2:0] gain_ratio_select;
		logic ratio_double_enable;
		logic comparator_source_select;
		logic dac_reference_select;
		logic hysteresis_enable;
		logic protect_enable;
		logic [7:0] dac_code;
		logic [7:0] amp_cal;
		logic [6:0] cmp_cal;
	} ocp_analog_type;

endpackage

// ### hw/ocp_ctrl.sv
// overload protection control, debounce and event logic with Avalon-MM registers
`timescale 1ns/10ps

// Notes on behaviour
// R01: rising protect signal sets flag, irq if enabled
// R02: 3-bit gain ratio select drives amplifier
// R03: ratio double bit drives amplifier
// R04: eight switch bits, one turns switch on
// R05: comparator source: zero amplifier, one pin
// R06: dac reference: zero supply, one pin
// R07: enable low forces raw comparator zero
// R08: debounce raw comparator on system clock
// R09: code zero bypass, else 2^n-1 stable cycles
// R10: debounced result is read-only status bit
// R11: polarity one inverts debounced result
// R12: only rising edge raises interrupt request
// R13: writable hysteresis enable bit
// R14: 8-bit dac code from data register
// R15: 2-bit input pin select field
// R16: unimplemented bits read zero
// R17: software pairs S4 or S5 with S7
// R18: amplifier mode set only by switch bits
// R19: flag sticky until software clears it
module ocp_ctrl (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	output logic [1:0] AVS_RESPONSE,
	input wire logic CMP_IN,
	output ocp_pkg::ocp_analog_type ANALOG_CTRL,
	output logic IRQ
);
	import ocp_pkg::*;

	// ****************************************
	// registers
	// ****************************************
	logic [1:0] pin_sel_q;
	logic [7:0] dac_code_q;
	logic [7:0] switch_q;
	logic enable_q;
	logic hyst_q;
	logic polarity_q;
	logic cmp_src_q;
	logic dac_ref_q;
	logic double_q;
	logic [2:0] gain_q;
	logic [2:0] deb_sel_q;
	logic [7:0] amp_cal_q;
	logic [6:0] cmp_cal_q;
	logic irq_status_q;
	logic irq_enable_q;
	logic wait_q;
	logic [31:0] rdata_q;
	logic [1:0] resp_q;
	logic irq_q;
	ocp_analog_type analog_q;
	logic [2:0] sync_q;
	logic raw_q;
	logic deb_q;
	logic [OCP_DEB_CNT_W-1:0] deb_cnt_q;
	logic event_prev_q;

	logic [5:0] byte_addr;
	logic wr_go;
	logic rd_go;
	logic wr_lane0;
	logic clear_hit;
	logic mapped;
	logic event_sig;
	logic event_rise;
	logic [OCP_DEB_CNT_W-1:0] deb_limit;

	// decoding used for read and write alike
	function automatic logic addr_mapped(input logic [5:0] a);
		addr_mapped = (a <= {1'b0, OCP_ADDR_IRQ_STATUS}) || (a == OCP_ADDR_IRQ_CLEAR)
			|| (a == OCP_ADDR_IRQ_ENABLE);
	endfunction

	// number of stable cycles for a debounce code, zero meaning bypass
	function automatic logic [OCP_DEB_CNT_W-1:0] deb_cycles(input logic [2:0] code);
		deb_cycles = OCP_DEB_CNT_W'((8'h01 << code) - 8'h01);
	endfunction

	// ****************************************
	// bus slave
	// ****************************************
	// one wait cycle per access: waitrequest drops for exactly one edge
	assign byte_addr = {AVS_ADDRESS, 2'b00};
	assign wr_go = AVS_WRITE && wait_q;
	assign rd_go = AVS_READ && wait_q;
	assign mapped = addr_mapped(byte_addr);
	// a write lands only on the edge that ends the wait, the one the master also sees
	assign wr_lane0 = AVS_WRITE && !wait_q && AVS_BYTEENABLE[0] && mapped;
	assign clear_hit = wr_lane0 && byte_addr == OCP_ADDR_IRQ_CLEAR && AVS_WRITEDATA[OCP_BIT_IRQ_PROTECT];

	// waitrequest straight from a flop, high through reset so nothing is taken early
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= !(wr_go || rd_go);
		end
	end

	// error code for holes in the map, kept with the answer it belongs to
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			resp_q <= 2'h0;
		end else if (wr_go || rd_go) begin
			resp_q <= mapped ? 2'h0 : 2'h3;
		end
	end

	assign AVS_WAITREQUEST = wait_q;
	assign AVS_RESPONSE = resp_q;

	// read data captured at request, stands during the acknowledge edge
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rdata_q <= 32'h00000000;
		end else if (rd_go) begin
			rdata_q <= 32'h00000000; // [R16]
			unique case (byte_addr)
				{1'b0, OCP_ADDR_INPUT_SOURCE}: rdata_q[1:0] <= pin_sel_q;
				{1'b0, OCP_ADDR_DAC_CODE}: rdata_q[7:0] <= dac_code_q;
				{1'b0, OCP_ADDR_SWITCH}: rdata_q[7:0] <= switch_q;
				{1'b0, OCP_ADDR_PROTECT}: begin
					rdata_q[OCP_BIT_ENABLE] <= enable_q;
					rdata_q[OCP_BIT_HYST] <= hyst_q;
					rdata_q[OCP_BIT_DEBOUNCED] <= deb_q; // [R10]
					rdata_q[OCP_BIT_POLARITY] <= polarity_q;
					rdata_q[OCP_BIT_CMP_SRC] <= cmp_src_q;
					rdata_q[OCP_BIT_DAC_REF] <= dac_ref_q;
				end
				{1'b0, OCP_ADDR_GAIN_DEB}: rdata_q[6:0] <= {double_q, gain_q, deb_sel_q};
				{1'b0, OCP_ADDR_AMP_CAL}: rdata_q[7:0] <= amp_cal_q;
				{1'b0, OCP_ADDR_CMP_CAL}: rdata_q[7:0] <= {raw_q, cmp_cal_q};
				{1'b0, OCP_ADDR_IRQ_STATUS}: rdata_q[OCP_BIT_IRQ_PROTECT] <= irq_status_q;
				OCP_ADDR_IRQ_ENABLE: rdata_q[OCP_BIT_IRQ_PROTECT] <= irq_enable_q;
				default: rdata_q <= 32'h00000000;
			endcase
		end
	end

	assign AVS_READDATA = rdata_q;

	// ****************************************
	// software control registers
	// ****************************************
	// one process per register keeps each write decode next to the bits it updates
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			pin_sel_q <= 2'h0;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_INPUT_SOURCE}) begin
			pin_sel_q <= AVS_WRITEDATA[1:0]; // [R15]
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			dac_code_q <= OCP_RST_ZERO;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_DAC_CODE}) begin
			dac_code_q <= AVS_WRITEDATA[7:0]; // [R14]
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			switch_q <= OCP_RST_SWITCH;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_SWITCH}) begin
			switch_q <= AVS_WRITEDATA[7:0]; // [R04] [R18]
		end
	end

	// bit 5 reads the debounced result and bits 3:2 are holes, so none of them store
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			enable_q <= 1'b0;
			hyst_q <= 1'b0;
			polarity_q <= 1'b0;
			cmp_src_q <= 1'b0;
			dac_ref_q <= 1'b0;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_PROTECT}) begin
			enable_q <= AVS_WRITEDATA[OCP_BIT_ENABLE];
			hyst_q <= AVS_WRITEDATA[OCP_BIT_HYST]; // [R13]
			polarity_q <= AVS_WRITEDATA[OCP_BIT_POLARITY];
			cmp_src_q <= AVS_WRITEDATA[OCP_BIT_CMP_SRC]; // [R05]
			dac_ref_q <= AVS_WRITEDATA[OCP_BIT_DAC_REF]; // [R06]
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			double_q <= 1'b0;
			gain_q <= 3'h0;
			deb_sel_q <= 3'h0;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_GAIN_DEB}) begin
			double_q <= AVS_WRITEDATA[OCP_BIT_DOUBLE]; // [R03]
			gain_q <= AVS_WRITEDATA[OCP_GAIN_LSB +: 3]; // [R02]
			deb_sel_q <= AVS_WRITEDATA[OCP_DEB_LSB +: 3];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			amp_cal_q <= OCP_RST_AMP_CAL;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_AMP_CAL}) begin
			amp_cal_q <= AVS_WRITEDATA[7:0];
		end
	end

	// the raw comparator bit shares this address but is read-only; only 6:0 store
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			cmp_cal_q <= OCP_RST_CMP_CAL;
		end else if (wr_lane0 && byte_addr == {1'b0, OCP_ADDR_CMP_CAL}) begin
			cmp_cal_q <= AVS_WRITEDATA[6:0];
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_enable_q <= 1'b0;
		end else if (wr_lane0 && byte_addr == OCP_ADDR_IRQ_ENABLE) begin
			irq_enable_q <= AVS_WRITEDATA[OCP_BIT_IRQ_PROTECT]; // [R01]
		end
	end

	// ****************************************
	// analog control outputs
	// ****************************************
	// registered so the front end never sees decode glitches
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			analog_q <= '0;
			analog_q.switch_controls <= OCP_RST_SWITCH;
			analog_q.amp_cal <= OCP_RST_AMP_CAL;
			analog_q.cmp_cal <= OCP_RST_CMP_CAL;
		end else begin
			analog_q.input_pin_select <= pin_sel_q; // [R15]
			analog_q.switch_controls <= switch_q; // [R04] [R18]
			analog_q.gain_ratio_select <= gain_q; // [R02]
			analog_q.ratio_double_enable <= double_q; // [R03]
			analog_q.comparator_source_select <= cmp_src_q; // [R05]
			analog_q.dac_reference_select <= dac_ref_q; // [R06]
			analog_q.hysteresis_enable <= hyst_q; // [R13]
			analog_q.protect_enable <= enable_q; // [R07]
			analog_q.dac_code <= dac_code_q; // [R14]
			analog_q.amp_cal <= amp_cal_q;
			analog_q.cmp_cal <= cmp_cal_q;
		end
	end

	assign ANALOG_CTRL = analog_q;

	// ****************************************
	// comparator input and debounce
	// ****************************************
	// three stages; the first is read only by the second
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sync_q <= 3'h0;
		end else begin
			sync_q <= {sync_q[1:0], CMP_IN};
		end
	end

	// level changes once stages two and three agree; disable forces zero
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			raw_q <= 1'b0;
		end else if (!enable_q) begin
			raw_q <= 1'b0; // [R07]
		end else if (sync_q[1] == sync_q[2]) begin
			raw_q <= sync_q[2];
		end
	end

	assign deb_limit = deb_cycles(deb_sel_q);

	// output follows raw once it has differed for deb_limit cycles
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			deb_q <= 1'b0;
			deb_cnt_q <= '0;
		end else if (deb_sel_q == 3'h0 || raw_q == deb_q) begin
			deb_q <= raw_q; // [R08] [R09]
			deb_cnt_q <= '0;
		end else if (deb_cnt_q >= deb_limit - OCP_DEB_CNT_W'(1)) begin
			deb_q <= raw_q; // [R09]
			deb_cnt_q <= '0;
		end else begin
			deb_cnt_q <= deb_cnt_q + OCP_DEB_CNT_W'(1); // [R08]
		end
	end

	// ****************************************
	// protect event and interrupt
	// ****************************************
	assign event_sig = deb_q ^ polarity_q; // [R11]
	assign event_rise = event_sig && !event_prev_q; // [R12]

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			event_prev_q <= 1'b0;
		end else begin
			event_prev_q <= event_sig;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_status_q <= 1'b0;
		end else if (event_rise) begin
			irq_status_q <= 1'b1; // [R01] [R19]
		end else if (clear_hit) begin
			irq_status_q <= 1'b0; // [R19]
		end
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_status_q && irq_enable_q; // [R01]
		end
	end

	assign IRQ = irq_q;

endmodule

// ### verif/ocp_ctrl_assertions.sv
// port checker for the overload protection block
`timescale 1ns/10ps
module ocp_ctrl_assertions (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire ocp_pkg::ocp_analog_type ANALOG_CTRL,
	input wire logic IRQ
);
	import ocp_pkg::*;
	logic wr;
	// a write counts only on the edge that ends its wait
	assign wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	a_dac_follow: assert property (
		wr && AVS_ADDRESS == 4'h1 |=> ##1 ANALOG_CTRL.dac_code == $past(AVS_WRITEDATA[7:0], 2))
		else $error("dac code wrong");
	a_switch_follow: assert property (
		wr && AVS_ADDRESS == 4'h2 |=> ##1 ANALOG_CTRL.switch_controls == $past(AVS_WRITEDATA[7:0], 2))
		else $error("switch bits wrong");
	a_gain_follow: assert property (
		wr && AVS_ADDRESS == 4'h4 |=> ##1
		{ANALOG_CTRL.ratio_double_enable, ANALOG_CTRL.gain_ratio_select} == $past(AVS_WRITEDATA[6:3], 2))
		else $error("gain bits wrong");
	a_ctrl_follow: assert property (
		wr && AVS_ADDRESS == 4'h3 |=> ##1 {ANALOG_CTRL.protect_enable, ANALOG_CTRL.hysteresis_enable,
		ANALOG_CTRL.comparator_source_select, ANALOG_CTRL.dac_reference_select} ==
		$past({AVS_WRITEDATA[7:6], AVS_WRITEDATA[1:0]}, 2))
		else $error("protect control bits wrong");
	a_reset_switch: assert property (
		$fell(RST) |-> ANALOG_CTRL.switch_controls == 8'hC8)
		else $error("switch reset value wrong");
	a_irq_sticky: assert property (
		IRQ && !AVS_WRITE && !$past(AVS_WRITE) |=> IRQ)
		else $error("irq dropped without software");
	a_irq_clear: assert property (
		wr && AVS_ADDRESS == 4'h8 && AVS_WRITEDATA[0] |=> ##1 !IRQ)
		else $error("irq not cleared");
	a_unused_zero: assert property (
		AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS == 4'h0 |=> AVS_READDATA[7:2] == 6'h00)
		else $error("unused source bits not zero");
endmodule
bind ocp_ctrl ocp_ctrl_assertions i_ocp_ctrl_assertions (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .ANALOG_CTRL(ANALOG_CTRL), .IRQ(IRQ));

// ### verif/ocp_front_model.sv
// behavioural analog front end: source select and comparator against the dac code
`timescale 1ns/10ps
module ocp_front_model (
	input wire ocp_pkg::ocp_analog_type ctrl,
	input wire logic [7:0] amp_level,
	input wire logic [7:0] pin_level,
	output logic cmp_out
);
	import ocp_pkg::*;
	// levels are already amplified; hysteresis is not modelled
	assign cmp_out = (ctrl.comparator_source_select ? pin_level : amp_level) > ctrl.dac_code;
endmodule

// ### verif/ocp_ctrl_tb.sv
// self-checking bench for the overload protection block
`timescale 1ns/10ps
module ocp_ctrl_tb;
	import ocp_pkg::*;
	localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'hC8, 8'h00, 8'h00, 8'h20, 8'h10, 8'h00};
	logic SYS_CLK = 1'b0;
	logic RST = 1'b1;
	logic [3:0] AVS_ADDRESS = 4'h0;
	logic AVS_READ = 1'b0;
	logic AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0] AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic [1:0] AVS_RESPONSE;
	logic CMP_IN;
	ocp_analog_type ANALOG_CTRL;
	logic IRQ;
	logic [7:0] amp_level = 8'h00;
	logic [7:0] pin_level = 8'h00;
	logic [31:0] q;
	logic [1:0] rsp;
	int miscompares = 0;
	int checked = 0;
	always #5 SYS_CLK = ~SYS_CLK;
	ocp_ctrl i_ocp_ctrl (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
		.CMP_IN(CMP_IN), .ANALOG_CTRL(ANALOG_CTRL), .IRQ(IRQ));
	ocp_front_model i_ocp_front_model (.ctrl(ANALOG_CTRL), .amp_level(amp_level), .pin_level(pin_level),
		.cmp_out(CMP_IN));
	task summarize;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// request held until the edge that sees waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		AVS_BYTEENABLE <= be;
		AVS_WRITE <= w;
		AVS_READ <= !w;
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
		if (AVS_WAITREQUEST !== 1'b0) begin
			miscompares++;
			summarize;
		end
		q = AVS_READDATA;
		rsp = AVS_RESPONSE;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task rd(input string n, input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00, 4'hF);
		chk(n, {24'h0, e}, q);
	endtask
	task wait_irq(input logic v);
		int n;
		n = 0;
		while (IRQ !== v && n < 300) begin
			@(posedge SYS_CLK);
			n++;
		end
		chk("irq", v, IRQ);
		if (IRQ !== v)
			summarize;
	endtask
	task t_regs;
		for (int a = 0; a < 8; a++)
			rd("reset value", a[3:0], RSTV[a]);
		wr(4'h1, 8'h5A);
		rd("dac", 4'h1, 8'h5A);
		chk("dac out", 8'h5A, ANALOG_CTRL.dac_code);
		wr(4'h2, 8'h37);
		rd("switch", 4'h2, 8'h37);
		chk("switch out", 8'h37, ANALOG_CTRL.switch_controls);
		wr(4'h3, 8'h6F);
		rd("protect", 4'h3, 8'h43);
		chk("ctrl out", 4'hE, {ANALOG_CTRL.hysteresis_enable, ANALOG_CTRL.comparator_source_select,
			ANALOG_CTRL.dac_reference_select, ANALOG_CTRL.protect_enable});
		for (int g = 0; g < 16; g++) begin
			wr(4'h0, {6'h3F, g[1:0]});
			wr(4'h4, {1'b1, g[3:0], 3'h5});
			rd("gain reg", 4'h4, {1'b0, g[3:0], 3'h5});
			chk("gain", g, {ANALOG_CTRL.ratio_double_enable, ANALOG_CTRL.gain_ratio_select});
			chk("pin", g[1:0], ANALOG_CTRL.input_pin_select);
		end
		bus(1'b1, 4'h1, 8'h11, 4'hE);
		rd("dac be0", 4'h1, 8'h5A);
		wr(4'h6, 8'hFF);
		rd("cmp cal", 4'h6, 8'h7F);
		wr(4'h6, 8'h10);
		rd("unmapped", 4'hC, 8'h00);
		chk("unmapped resp", 2'b11, rsp);
		$display("test registers done");
	endtask
	task t_event;
		wr(4'h2, 8'h90);
		wr(4'h1, 8'h40);
		wr(4'h4, 8'h00);
		wr(4'h9, 8'h01);
		wr(4'h3, 8'h80);
		amp_level <= 8'h80;
		wait_irq(1'b1);
		rd("raw", 4'h6, 8'h90);
		wr(4'h3, 8'h80);
		rd("debounced", 4'h3, 8'hA0);
		wr(4'h8, 8'h01);
		wait_irq(1'b0);
		wr(4'h3, 8'h90);
		amp_level <= 8'h00;
		wait_irq(1'b1);
		wr(4'h8, 8'h01);
		amp_level <= 8'h80;
		repeat (30) @(posedge SYS_CLK);
		chk("rise inverted", 0, IRQ);
		amp_level <= 8'h00;
		wait_irq(1'b1);
		wr(4'h9, 8'h00);
		wait_irq(1'b0);
		rd("status", 4'h7, 8'h01);
		$display("test event done");
	endtask
	task t_debounce;
		wr(4'h3, 8'h80);
		wr(4'h4, 8'h03);
		wr(4'h8, 8'h01);
		wr(4'h9, 8'h01);
		amp_level <= 8'h80;
		repeat (5) @(posedge SYS_CLK);
		amp_level <= 8'h00;
		repeat (30) @(posedge SYS_CLK);
		chk("short pulse", 0, IRQ);
		amp_level <= 8'h80;
		wait_irq(1'b1);
		wr(4'h3, 8'h00);
		repeat (20) @(posedge SYS_CLK);
		rd("raw off", 4'h6, 8'h10);
		rd("protect off", 4'h3, 8'h00);
		$display("test debounce done");
	endtask
	task t_pin;
		wr(4'h4, 8'h00);
		wr(4'h3, 8'h02);
		wr(4'h3, 8'h82);
		wr(4'h8, 8'h01);
		repeat (20) @(posedge SYS_CLK);
		chk("pin idle", 0, IRQ);
		pin_level <= 8'h80;
		wait_irq(1'b1);
		$display("test pin source done");
	endtask
	initial begin
		repeat (4) @(posedge SYS_CLK);
		RST <= 1'b0;
		@(posedge SYS_CLK);
		t_regs;
		t_event;
		t_debounce;
		t_pin;
		summarize;
	end
endmodule
